// *** logic/host_port_pin_strap_mux.sv ***
// pin function selection for host data pins and control pin 0
`timescale 1ns/100ps
module host_port_pin_strap_mux (
   input  wire logic                          sys_clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          boot_strap_select_pin_i,
   // pin pads
   input  wire logic [host_port_pkg::DATA_W-1:0] host_port_data_pins_i,
   output logic [host_port_pkg::DATA_W-1:0]   host_port_data_pins_o,
   output logic [host_port_pkg::DATA_W-1:0]   host_port_data_pins_oe_o,
   input  wire logic                          host_control_pin_0_i,
   output logic                               host_control_pin_0_o,
   output logic                               host_control_pin_0_oe_o,
   output logic                               bus_holder_en_o,
   // software holder control from the external bus control register
   input  wire logic                          holder_wr_i,
   input  wire logic                          holder_wdata_i,
   // parallel io user side, bits 43..36 and 44
   input  wire logic [host_port_pkg::DATA_W-1:0] parallel_io_bits_upper_byte_out_i,
   input  wire logic [host_port_pkg::DATA_W-1:0] parallel_io_bits_upper_byte_dir_i,
   output logic [host_port_pkg::DATA_W-1:0]   parallel_io_bits_upper_byte_o,
   input  wire logic                          parallel_io_bit_ctl0_out_i,
   input  wire logic                          parallel_io_bit_ctl0_dir_i,
   output logic                               parallel_io_bit_ctl0_o,
   // host interface user side
   input  wire logic [host_port_pkg::DATA_W-1:0] host_if_data_bus_out_i,
   input  wire logic                          host_if_data_bus_drive_i,
   output logic [host_port_pkg::DATA_W-1:0]   host_if_data_bus_o,
   output logic                               host_addr_strobe_o,
   output logic                               host_byte_valid_o,
   output logic                               host_byte_second_o,
   output logic                               host_mode_o,
   output logic                               mux_mode_o
);
   import host_port_pkg::*;

   mux_state_t state_r;
   mux_state_t state_nxt;

   logic [1:0]        data_sync1_r [DATA_W];
   logic [DATA_W-1:0] data_sync_r;
   logic [1:0]        ctl_sync_r;
   logic              strobe_prev_r;

   ////////////////////////////////////////////////////////////////////////
   // pin input synchronisers, one per data bit and one for control pin 0
   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++) begin : g_sync
         always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
               data_sync1_r[gi] <= SYNC_RST;
            end else begin
               data_sync1_r[gi] <= {data_sync1_r[gi][0],
                                    host_port_data_pins_i[gi]};
            end
         end
         assign data_sync_r[gi] = data_sync1_r[gi][1];
      end
   endgenerate

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctl_sync_r    <= SYNC_RST;
         strobe_prev_r <= 1'h0;
      end else begin
         ctl_sync_r    <= {ctl_sync_r[0], host_control_pin_0_i};
         strobe_prev_r <= ctl_sync_r[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state update
   logic strobe_rise;
   assign strobe_rise = ctl_sync_r[1] & ~strobe_prev_r;

   always_comb begin
      state_nxt = state_r;
      state_nxt.strap_sync = {state_r.strap_sync[0],
                              boot_strap_select_pin_i};
      if (rst_i) begin
         // strap is tracked while reset is held, frozen on release
         state_nxt.in_reset  = 1'h1;
         state_nxt.host_mode = state_r.strap_sync[1];
         state_nxt.holder_en = HOLDER_RST_ON;
         state_nxt.phase     = BYTE_FIRST;
         state_nxt.data.oe   = OE_RST;
         state_nxt.data.dout = '0;
         state_nxt.ctl       = '0;
      end else begin
         state_nxt.in_reset = 1'h0;
         if (holder_wr_i) begin
            state_nxt.holder_en = holder_wdata_i;
         end
         if (state_r.host_mode == MODE_HOST) begin
            // two byte cycle, every strobe rise marks a byte and toggles the phase
            case (state_r.phase)
               BYTE_FIRST: begin
                  if (strobe_rise) begin
                     state_nxt.phase = BYTE_SECOND;
                  end
               end
               BYTE_SECOND: begin
                  if (strobe_rise) begin
                     state_nxt.phase = BYTE_FIRST;
                  end
               end
               default: state_nxt.phase = BYTE_FIRST;
            endcase
            state_nxt.data.oe   = {DATA_W{host_if_data_bus_drive_i}};
            state_nxt.data.dout = host_if_data_bus_out_i;
            state_nxt.ctl       = '0;
         end else begin
            state_nxt.data.oe   = parallel_io_bits_upper_byte_dir_i;
            state_nxt.data.dout = parallel_io_bits_upper_byte_out_i;
            state_nxt.ctl.oe    = parallel_io_bit_ctl0_dir_i;
            state_nxt.ctl.dout  = parallel_io_bit_ctl0_out_i;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_r.in_reset   <= 1'h1;
         state_r.holder_en  <= HOLDER_RST_ON;
         state_r.phase      <= BYTE_FIRST;
         state_r.data       <= '0;
         state_r.ctl        <= '0;
         state_r.strap_sync <= state_nxt.strap_sync;
         state_r.host_mode  <= state_nxt.host_mode;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   logic host_sel;
   assign host_sel = (state_r.host_mode == MODE_HOST) & ~state_r.in_reset;

   assign host_port_data_pins_o    = state_r.data.dout;
   assign host_port_data_pins_oe_o = state_r.data.oe;
   assign host_control_pin_0_o     = state_r.ctl.dout;
   assign host_control_pin_0_oe_o  = state_r.ctl.oe;
   assign bus_holder_en_o          = state_r.holder_en;
   assign host_mode_o              = host_sel;
   assign mux_mode_o               = host_sel;
   // data bus carries address and data alike
   assign host_if_data_bus_o       = host_sel ? data_sync_r : '0;
   assign host_addr_strobe_o       = host_sel & ctl_sync_r[1];
   assign host_byte_valid_o        = host_sel & strobe_rise;
   assign host_byte_second_o       = state_r.phase == BYTE_SECOND;
   assign parallel_io_bits_upper_byte_o = host_sel ? '0 : data_sync_r;
   assign parallel_io_bit_ctl0_o   = host_sel ? 1'h0 : ctl_sync_r[1];

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_strap_frozen;
      @(posedge sys_clk_i) disable iff (rst_i)
         !$past(rst_i) |-> $stable(state_r.host_mode);
   endproperty
   a_strap_frozen: assert property (p_strap_frozen)
      else $error("strap selection changed outside reset");

   property p_reset_inputs;
      @(posedge sys_clk_i)
         $fell(rst_i) |-> (host_port_data_pins_oe_o == OE_RST)
            && !host_control_pin_0_oe_o;
   endproperty
   a_reset_inputs: assert property (p_reset_inputs)
      else $error("pins not inputs at reset release");

   property p_holder_reset;
      @(posedge sys_clk_i) $fell(rst_i) |-> bus_holder_en_o;
   endproperty
   a_holder_reset: assert property (p_holder_reset)
      else $error("bus holder off at reset release");

   property p_host_no_ctl_drive;
      @(posedge sys_clk_i) disable iff (rst_i)
         host_sel |-> !host_control_pin_0_oe_o;
   endproperty
   a_host_no_ctl_drive: assert property (p_host_no_ctl_drive)
      else $error("address strobe pin driven in host mode");

   property p_pio_route;
      @(posedge sys_clk_i) disable iff (rst_i)
         (!host_sel && !$past(rst_i) && !$past(rst_i, 2)) |->
            host_port_data_pins_oe_o
               == $past(parallel_io_bits_upper_byte_dir_i);
   endproperty
   a_pio_route: assert property (p_pio_route)
      else $error("parallel io direction not routed");

   property p_host_route;
      @(posedge sys_clk_i) disable iff (rst_i)
         (host_sel && !$past(rst_i) && !$past(rst_i, 2)) |->
            host_port_data_pins_o == $past(host_if_data_bus_out_i);
   endproperty
   a_host_route: assert property (p_host_route)
      else $error("host data not routed");

   property p_two_bytes;
      @(posedge sys_clk_i) disable iff (rst_i)
         (host_sel && strobe_rise && !host_byte_second_o) |=>
            host_byte_second_o;
   endproperty
   a_two_bytes: assert property (p_two_bytes)
      else $error("first byte did not advance to second");

   property p_release_effect;
      @(posedge sys_clk_i)
         $fell(rst_i) |=> (host_sel == state_r.host_mode);
   endproperty
   a_release_effect: assert property (p_release_effect)
      else $error("pin function not applied on release");

   // strap reaches the mode bit on the third edge, counting the edge that samples it
   property p_strap_capture;
      @(posedge sys_clk_i)
         ($past(rst_i) && $past(rst_i, 3)) |->
            state_r.host_mode == $past(boot_strap_select_pin_i, 3);
   endproperty
   a_strap_capture: assert property (p_strap_capture)
      else $error("strap not captured during reset");

   property p_reset_drives_off;
      @(posedge sys_clk_i)
         rst_i |=> (host_port_data_pins_oe_o == OE_RST)
            && !host_control_pin_0_oe_o;
   endproperty
   a_reset_drives_off: assert property (p_reset_drives_off)
      else $error("pin driven while reset held");

   property p_pio_data_out;
      @(posedge sys_clk_i) disable iff (rst_i)
         (!host_sel && !$past(rst_i) && !$past(rst_i, 2)) |->
            host_port_data_pins_o
               == $past(parallel_io_bits_upper_byte_out_i);
   endproperty
   a_pio_data_out: assert property (p_pio_data_out)
      else $error("parallel io value not routed");

   property p_pio_ctl_route;
      @(posedge sys_clk_i) disable iff (rst_i)
         (!host_sel && !$past(rst_i) && !$past(rst_i, 2)) |->
            host_control_pin_0_oe_o == $past(parallel_io_bit_ctl0_dir_i)
            && host_control_pin_0_o == $past(parallel_io_bit_ctl0_out_i);
   endproperty
   a_pio_ctl_route: assert property (p_pio_ctl_route)
      else $error("parallel io bit 44 not routed");

   property p_host_oe_route;
      @(posedge sys_clk_i) disable iff (rst_i)
         (host_sel && !$past(rst_i) && !$past(rst_i, 2)) |->
            host_port_data_pins_oe_o
               == {DATA_W{$past(host_if_data_bus_drive_i)}};
   endproperty
   a_host_oe_route: assert property (p_host_oe_route)
      else $error("host drive enable not routed");

   // the function not chosen reads back as zero on its user side
   property p_host_side_gated;
      @(posedge sys_clk_i)
         !host_sel |-> host_if_data_bus_o == '0 && !host_addr_strobe_o
            && !host_byte_valid_o;
   endproperty
   a_host_side_gated: assert property (p_host_side_gated)
      else $error("host side active in parallel io mode");

   property p_pio_side_gated;
      @(posedge sys_clk_i)
         host_sel |-> parallel_io_bits_upper_byte_o == '0
            && !parallel_io_bit_ctl0_o;
   endproperty
   a_pio_side_gated: assert property (p_pio_side_gated)
      else $error("parallel io side active in host mode");

   property p_second_closes;
      @(posedge sys_clk_i) disable iff (rst_i)
         (host_sel && strobe_rise && host_byte_second_o) |=>
            !host_byte_second_o;
   endproperty
   a_second_closes: assert property (p_second_closes)
      else $error("second byte did not close the pair");

   property p_phase_steady;
      @(posedge sys_clk_i) disable iff (rst_i)
         !strobe_rise |=> $stable(host_byte_second_o);
   endproperty
   a_phase_steady: assert property (p_phase_steady)
      else $error("byte phase moved without a strobe");

   property p_holder_write;
      @(posedge sys_clk_i) disable iff (rst_i)
         holder_wr_i |=> bus_holder_en_o == $past(holder_wdata_i);
   endproperty
   a_holder_write: assert property (p_holder_write)
      else $error("bus holder write not applied");

   property p_holder_steady;
      @(posedge sys_clk_i) disable iff (rst_i)
         !holder_wr_i |=> $stable(bus_holder_en_o);
   endproperty
   a_holder_steady: assert property (p_holder_steady)
      else $error("bus holder changed without a write");
endmodule : host_port_pin_strap_mux

// *** common/host_port_pkg.sv ***
// constants and carrier types for the host port pin strap mux
package host_port_pkg;
   localparam int          DATA_W         = 8;
   localparam logic        HOLDER_RST_ON  = 1'h1;
   localparam logic        MODE_PIO       = 1'h0;
   localparam logic        MODE_HOST      = 1'h1;
   localparam logic [7:0]  OE_RST         = 8'h00;
   localparam logic [1:0]  SYNC_RST       = 2'h0;

   typedef enum logic {BYTE_FIRST, BYTE_SECOND} byte_phase_t;

   // pin side of the data bus, one enable per bit
   typedef struct packed {
      logic [DATA_W-1:0] dout;
      logic [DATA_W-1:0] oe;
   } data_drive_t;

   // pin side of control pin 0
   typedef struct packed {
      logic dout;
      logic oe;
   } ctl_drive_t;

   typedef struct packed {
      logic              in_reset;
      logic              host_mode;
      logic              holder_en;
      logic [1:0]        strap_sync;
      byte_phase_t       phase;
      data_drive_t       data;
      ctl_drive_t        ctl;
   } mux_state_t;
endpackage : host_port_pkg

// *** dv/host_model.sv ***
// host processor model on the host port pads
`timescale 1ns/100ps
module host_model (
   input  wire logic       clk_i,
   input  wire logic       hold_i,
   input  wire logic [7:0] dev_d_i,
   input  wire logic [7:0] dev_oe_i,
   input  wire logic       dev_c_i,
   input  wire logic       dev_c_oe_i,
   output logic [7:0]      pad_d_o,
   output logic            pad_c_o
);
   logic [7:0] hd_r   = 8'h00;
   logic       hoe_r  = 1'h0;
   logic       has_r  = 1'h0;
   logic [7:0] last_r = 8'h00;
   // released lines keep their last driven level while the holders are on,
   // otherwise they show its inverse
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (dev_oe_i[i]) begin
            pad_d_o[i] = dev_d_i[i];
         end else if (hoe_r) begin
            pad_d_o[i] = hd_r[i];
         end else begin
            pad_d_o[i] = hold_i ? last_r[i] : ~last_r[i];
         end
      end
      pad_c_o = dev_c_oe_i ? dev_c_i : has_r;
   end
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 8; i++) begin
         if (dev_oe_i[i] || hoe_r) begin
            last_r[i] <= pad_d_o[i];
         end
      end
   end
   // one byte of the pair: data first, strobe rises a cycle later
   task automatic drive_byte(input logic [7:0] b);
      @(posedge clk_i) #1;
      hd_r = b;
      hoe_r = 1'h1;
      @(posedge clk_i) #1;
      has_r = 1'h1;
   endtask : drive_byte
   task automatic release_byte();
      @(posedge clk_i) #1;
      has_r = 1'h0;
      hoe_r = 1'h0;
   endtask : release_byte
endmodule : host_model

// *** dv/tb.sv ***
// self-checking bench for the host port pin strap mux
`timescale 1ns/100ps
module tb;
   import host_port_pkg::*;
   logic       clk = 1'h0;
   logic       rst = 1'h1;
   logic       strap = 1'h0;
   logic       hwr = 1'h0;
   logic       hwd = 1'h0;
   logic [7:0] pout = 8'h00;
   logic [7:0] pdir = 8'h00;
   logic       cout = 1'h0;
   logic       cdir = 1'h0;
   logic [7:0] hout = 8'h00;
   logic       hdrv = 1'h0;
   logic [7:0] pad_d, d_o, d_oe, pio_o, hif_o;
   logic       pad_c, c_o, c_oe, hold, pio_c, has, bval, bsec, hm, mm;
   int         errors = 0;
   int         n_checks = 0;
   host_port_pin_strap_mux dut (.sys_clk_i(clk), .rst_i(rst),
      .boot_strap_select_pin_i(strap), .host_port_data_pins_i(pad_d),
      .host_port_data_pins_o(d_o), .host_port_data_pins_oe_o(d_oe),
      .host_control_pin_0_i(pad_c), .host_control_pin_0_o(c_o),
      .host_control_pin_0_oe_o(c_oe), .bus_holder_en_o(hold),
      .holder_wr_i(hwr), .holder_wdata_i(hwd),
      .parallel_io_bits_upper_byte_out_i(pout),
      .parallel_io_bits_upper_byte_dir_i(pdir),
      .parallel_io_bits_upper_byte_o(pio_o),
      .parallel_io_bit_ctl0_out_i(cout), .parallel_io_bit_ctl0_dir_i(cdir),
      .parallel_io_bit_ctl0_o(pio_c), .host_if_data_bus_out_i(hout),
      .host_if_data_bus_drive_i(hdrv), .host_if_data_bus_o(hif_o),
      .host_addr_strobe_o(has), .host_byte_valid_o(bval),
      .host_byte_second_o(bsec), .host_mode_o(hm), .mux_mode_o(mm));
   host_model host (.clk_i(clk), .hold_i(hold), .dev_d_i(d_o),
      .dev_oe_i(d_oe), .dev_c_i(c_o), .dev_c_oe_i(c_oe), .pad_d_o(pad_d),
      .pad_c_o(pad_c));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////
   task automatic do_reset(input logic s);
      strap = s;
      rst = 1'h1;
      tick(12);
      rst = 1'h0;
      tick(2);
      chk({6'h00, hm, mm}, {6'h00, s, s}, "mode");
      chk(d_oe, OE_RST, "data oe");
      chk({7'h00, c_oe}, 8'h00, "ctl oe");
      chk({7'h00, hold}, 8'h01, "holder");
   endtask : do_reset
   task automatic t_pio();
      do_reset(MODE_PIO);
      pdir = 8'hff;
      pout = 8'ha5;
      cdir = 1'h1;
      cout = 1'h1;
      tick(1);
      chk(d_oe, 8'hff, "pio oe");
      chk(d_o, 8'ha5, "pio out");
      chk({6'h00, c_oe, c_o}, 8'h03, "ctl out");
      pdir = 8'h00;
      cdir = 1'h0;
      host.drive_byte(8'h3c);
      tick(4);
      chk(pio_o, 8'h3c, "pio in");
      chk({6'h00, pio_c, has}, 8'h02, "ctl in");
      chk(hif_o, 8'h00, "hif idle");
      host.release_byte();
      strap = 1'h1;
      tick(6);
      chk({7'h00, hm}, 8'h00, "strap held");
      chk(pio_o, 8'h3c, "holder keeps");
      hwr = 1'h1;
      hwd = 1'h0;
      tick(1);
      hwr = 1'h0;
      tick(1);
      chk({7'h00, hold}, 8'h00, "holder off");
      tick(1);
      chk(pio_o, 8'hc3, "holder released");
   endtask : t_pio
   task automatic t_host();
      logic [7:0] b;
      int         k;
      do_reset(MODE_HOST);
      for (int i = 0; i < 2; i++) begin
         b = (i == 0) ? 8'h81 : 8'h7e;
         host.drive_byte(b);
         k = 0;
         while (bval !== 1'h1 && k < 10) begin
            tick(1);
            k++;
         end
         chk({7'h00, bval}, 8'h01, "byte strobe");
         chk(hif_o, b, "hif data");
         chk({6'h00, has, bsec}, {6'h00, 1'h1, i[0]}, "phase");
         tick(1);
         chk({6'h00, bval, bsec}, {7'h00, ~i[0]}, "phase next");
         host.release_byte();
      end
      hdrv = 1'h1;
      hout = 8'h5a;
      tick(1);
      chk(d_oe, 8'hff, "hif oe");
      chk(d_o, 8'h5a, "hif out");
      chk({7'h00, c_oe}, 8'h00, "strobe in");
      hdrv = 1'h0;
      chk(pio_o, 8'h00, "pio gated");
      chk({7'h00, pio_c}, 8'h00, "ctl gated");
      strap = 1'h0;
      tick(6);
      chk({7'h00, hm}, 8'h01, "strap held host");
   endtask : t_host
   ////////////////////////////////////////////////////////////////////////
   initial begin
      t_pio();
      t_host();
      do_reset(MODE_PIO);
      end_sim();
   end
   // whole run is under a hundred cycles
   initial begin
      repeat (2000) @(posedge clk);
      errors++;
      end_sim();
   end
endmodule : tb
